// ===== arfb_byte_if.sv
`timescale 1ns/1ps
interface arfb_byte_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ===== arfb_frame_builder.sv
`timescale 1ns/1ps
module arfb_frame_builder
    import arfb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic [7:0] rsp_frame_id,
    input wire logic [7:0] rsp_cmd_hi,
    input wire logic [7:0] rsp_cmd_lo,
    input wire logic [7:0] rsp_status,
    input wire logic rsp_is_query,
    input wire logic [4:0] rsp_data_len,
    input wire logic [ARFB_DATA_MAX*8-1:0] rsp_data,
    input wire logic ev_valid,
    output logic ev_ready,
    input wire logic [7:0] ev_code,
    input wire logic coord_formed,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic frame_busy,
    output logic [7:0] drop_count
);
    arfb_byte_if byte_bus ();

    arfb_state_type state_r;
    logic is_cmd_r;
    logic [5:0] ofs_r;
    logic [5:0] last_ofs_r;
    logic [7:0] sum_r;
    logic [7:0] id_r;
    logic [7:0] cmd_hi_r;
    logic [7:0] cmd_lo_r;
    logic [7:0] cst_r;
    logic [7:0] ev_r;
    logic [15:0] len_r;
    logic [7:0] data_r [ARFB_DATA_MAX];
    logic coord_pend_r;
    logic coord_prev_r;
    logic rsp_ready_r;
    logic ev_ready_r;
    logic [7:0] byte_now;
    logic take_rsp;
    logic take_ev;
    logic take_coord;
    logic [4:0] dlen_eff;

    // Checksum byte from a running sum of offsets three onward
    function automatic logic [7:0] arfb_csum(input logic [7:0] sum);
        return ARFB_CSUM_BASE - sum;
    endfunction

    // Clamp the data length to what the array holds
    function automatic logic [4:0] arfb_clamp(input logic [4:0] n);
        return (n > ARFB_DLEN_MAX) ? ARFB_DLEN_MAX : n;
    endfunction

    // Writes carry no data; queries carry the clamped register value
    assign dlen_eff = rsp_is_query ? arfb_clamp(rsp_data_len) : 5'h00;

    // Requests are taken only when idle; coordinator start beats other events
    assign take_rsp = (state_r == ARFB_IDLE) && rsp_valid;
    assign take_coord = (state_r == ARFB_IDLE) && !rsp_valid && coord_pend_r;
    assign take_ev = (state_r == ARFB_IDLE) && !rsp_valid && !coord_pend_r && ev_valid;

    // Byte selection by offset
    always_comb begin
        byte_now = 8'h00;
        if (ofs_r == ARFB_OFS_DELIM) begin
            byte_now = ARFB_DELIM;
        end else if (ofs_r == ARFB_OFS_LEN_HI) begin
            byte_now = len_r[15:8];
        end else if (ofs_r == ARFB_OFS_LEN_LO) begin
            byte_now = len_r[7:0];
        end else if (ofs_r == ARFB_OFS_TYPE) begin
            byte_now = is_cmd_r ? ARFB_TYPE_CMD_RSP : ARFB_TYPE_STATUS;
        end else if (!is_cmd_r) begin
            byte_now = ev_r;
        end else if (ofs_r == ARFB_OFS_ID) begin
            byte_now = id_r;
        end else if (ofs_r == ARFB_OFS_CMD0) begin
            byte_now = cmd_hi_r;
        end else if (ofs_r == ARFB_OFS_CMD1) begin
            byte_now = cmd_lo_r;
        end else if (ofs_r == ARFB_OFS_CST) begin
            byte_now = cst_r;
        end else begin
            byte_now = data_r[4'(ofs_r - ARFB_OFS_DATA)];
        end
        if (state_r == ARFB_CSUM) begin
            byte_now = arfb_csum(sum_r);
        end
    end

    assign byte_bus.data = byte_now;
    assign byte_bus.valid = (state_r != ARFB_IDLE);

    // Frame sequencer; each offset advances only on acceptance
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ARFB_IDLE;
            ofs_r <= 6'h00;
            sum_r <= 8'h00;
        end else begin
            case (state_r)
                ARFB_IDLE: begin
                    ofs_r <= 6'h00;
                    sum_r <= 8'h00;
                    if ((take_rsp && rsp_frame_id != ARFB_FRAME_ID_NONE) || take_coord
                        || take_ev) begin
                        state_r <= ARFB_BODY;
                    end
                end
                ARFB_BODY: begin
                    if (byte_bus.ready) begin
                        ofs_r <= ofs_r + 6'h01;
                        if (ofs_r >= ARFB_OFS_TYPE) begin
                            sum_r <= sum_r + byte_now;
                        end
                        if (ofs_r == last_ofs_r) begin
                            state_r <= ARFB_CSUM;
                        end
                    end
                end
                ARFB_CSUM: begin
                    if (byte_bus.ready) begin
                        state_r <= ARFB_IDLE;
                    end
                end
                default: begin
                    state_r <= ARFB_IDLE;
                end
            endcase
        end
    end

    // Frame contents captured on acceptance; length counts body only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            is_cmd_r <= 1'b0;
            id_r <= 8'h00;
            cmd_hi_r <= 8'h00;
            cmd_lo_r <= 8'h00;
            cst_r <= 8'h00;
            ev_r <= 8'h00;
            len_r <= 16'h0000;
            last_ofs_r <= 6'h00;
        end else if (take_rsp) begin
            is_cmd_r <= 1'b1;
            id_r <= rsp_frame_id;
            cmd_hi_r <= rsp_cmd_hi;
            cmd_lo_r <= rsp_cmd_lo;
            cst_r <= rsp_status;
            len_r <= ARFB_CMD_HDR_LEN + {11'h000, dlen_eff};
            last_ofs_r <= ARFB_OFS_CST + {1'b0, dlen_eff};
        end else if (take_coord || take_ev) begin
            is_cmd_r <= 1'b0;
            ev_r <= take_coord ? ARFB_EV_COORD_START : ev_code;
            len_r <= ARFB_STAT_LEN;
            last_ofs_r <= ARFB_OFS_EV;
        end
    end

    // Data payload held so the requester can move on to the next reply
    always_ff @(posedge sys_clk) begin
        if (take_rsp) begin
            for (int i = 0; i < ARFB_DATA_MAX; i++) begin
                data_r[i] <= rsp_data[i*8 +: 8];
            end
        end
    end

    // Coordinator start latched as a pending event; set beats clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            coord_prev_r <= 1'b0;
            coord_pend_r <= 1'b0;
        end else begin
            coord_prev_r <= coord_formed;
            if (coord_formed && !coord_prev_r) begin
                coord_pend_r <= 1'b1;
            end else if (take_coord) begin
                coord_pend_r <= 1'b0;
            end
        end
    end

    // One-cycle acceptance pulses; each reply is its own request
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ready_r <= 1'b0;
            ev_ready_r <= 1'b0;
            drop_count <= 8'h00;
            frame_busy <= 1'b0;
        end else begin
            rsp_ready_r <= take_rsp && !rsp_ready_r;
            ev_ready_r <= take_ev && !ev_ready_r;
            // Checksum may still sit in the output stage after the sequencer idles
            frame_busy <= (state_r != ARFB_IDLE) || take_rsp || take_ev || take_coord
                || (tx_valid && !tx_ready);
            if (take_rsp && !rsp_ready_r && rsp_frame_id == ARFB_FRAME_ID_NONE) begin
                drop_count <= drop_count + 8'h01;
            end
        end
    end

    assign rsp_ready = rsp_ready_r;
    assign ev_ready = ev_ready_r;

    arfb_tx_stage u_stage (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_bus(byte_bus),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );
endmodule

// ===== arfb_frame_builder_sva.sv
`timescale 1ns/1ps
// Handshake and byte-stream checks on the builder ports
module arfb_sva
    import arfb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_frame_id,
    input wire logic ev_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic frame_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A frame opens with the delimiter one cycle after the ready pulse
    sequence delim_s;
        ##1 tx_valid && tx_data == ARFB_DELIM;
    endsequence
    hold_stall_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("byte moved in stall");
    drop_accept_a: assert property (
        $fell(tx_valid) |-> $past(tx_ready)) else $error("byte withdrawn unaccepted");
    one_take_a: assert property (
        !(rsp_ready && ev_ready)) else $error("two requests taken at once");
    rsp_start_a: assert property (
        rsp_ready && $past(rsp_frame_id) != 8'h00 |-> delim_s) else $error("reply did not open");
    ev_start_a: assert property (
        ev_ready |-> delim_s) else $error("status frame did not open");
    zero_quiet_a: assert property (
        rsp_ready && $past(rsp_frame_id) == 8'h00 |-> !tx_valid ##1 !tx_valid) else $error("zero id sent");
    ready_pulse_a: assert property (
        rsp_ready |=> !rsp_ready) else $error("ready longer than a pulse");
    busy_cover_a: assert property (
        tx_valid |-> frame_busy) else $error("byte offered while not busy");
endmodule
bind arfb_frame_builder arfb_sva chk (.sys_clk(sys_clk), .rst_b(rst_b), .rsp_ready(rsp_ready),
    .rsp_frame_id(rsp_frame_id), .ev_ready(ev_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .frame_busy(frame_busy));

// ===== arfb_host_model.sv
`timescale 1ns/1ps
// Host end of the byte stream; slow mode accepts every other cycle
module arfb_host_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic slow
);
    logic [7:0] got[$];
    logic ph_r = 1'b0;
    initial tx_ready = 1'b0;
    // Any code is kept, and replies sharing an id stay separate frames
    always @(posedge sys_clk) begin
        if (rst_b && tx_valid && tx_ready) got.push_back(tx_data);
        ph_r <= ~ph_r;
        tx_ready <= #1 rst_b && (!slow || ph_r);
    end
endmodule

// ===== arfb_pkg.sv
package arfb_pkg;
    localparam logic [7:0] ARFB_DELIM = 8'h7E;
    localparam logic [7:0] ARFB_CSUM_BASE = 8'hFF;
    localparam logic [7:0] ARFB_TYPE_CMD_RSP = 8'h88;
    localparam logic [7:0] ARFB_TYPE_STATUS = 8'h8A;
    localparam logic [7:0] ARFB_FRAME_ID_NONE = 8'h00;
    // Command outcome codes
    localparam logic [7:0] ARFB_CST_OK = 8'h00;
    localparam logic [7:0] ARFB_CST_ERROR = 8'h01;
    localparam logic [7:0] ARFB_CST_BAD_CMD = 8'h02;
    localparam logic [7:0] ARFB_CST_BAD_PARAM = 8'h03;
    localparam logic [7:0] ARFB_CST_TX_FAIL = 8'h04;
    // Unsolicited status codes
    localparam logic [7:0] ARFB_EV_HW_RESET = 8'h00;
    localparam logic [7:0] ARFB_EV_WDT_RESET = 8'h01;
    localparam logic [7:0] ARFB_EV_JOINED = 8'h02;
    localparam logic [7:0] ARFB_EV_DISASSOC = 8'h03;
    localparam logic [7:0] ARFB_EV_COORD_START = 8'h06;
    localparam logic [7:0] ARFB_EV_KEY_UPDATE = 8'h07;
    localparam logic [7:0] ARFB_EV_SUPPLY_LIMIT = 8'h0D;
    localparam logic [7:0] ARFB_EV_CFG_IN_JOIN = 8'h11;
    localparam logic [7:0] ARFB_EV_STACK_ERR = 8'h80;
    // Frame geometry
    localparam int ARFB_DATA_MAX = 16;
    localparam logic [4:0] ARFB_DLEN_MAX = 5'h10;
    localparam logic [15:0] ARFB_CMD_HDR_LEN = 16'h0005;
    localparam logic [15:0] ARFB_STAT_LEN = 16'h0002;
    localparam logic [5:0] ARFB_OFS_DELIM = 6'h00;
    localparam logic [5:0] ARFB_OFS_LEN_HI = 6'h01;
    localparam logic [5:0] ARFB_OFS_LEN_LO = 6'h02;
    localparam logic [5:0] ARFB_OFS_TYPE = 6'h03;
    localparam logic [5:0] ARFB_OFS_ID = 6'h04;
    localparam logic [5:0] ARFB_OFS_CMD0 = 6'h05;
    localparam logic [5:0] ARFB_OFS_CMD1 = 6'h06;
    localparam logic [5:0] ARFB_OFS_CST = 6'h07;
    localparam logic [5:0] ARFB_OFS_DATA = 6'h08;
    localparam logic [5:0] ARFB_OFS_EV = 6'h04;
    typedef enum logic [1:0] {ARFB_IDLE, ARFB_BODY, ARFB_CSUM} arfb_state_type;
endpackage

// ===== arfb_tx_stage.sv
`timescale 1ns/1ps
// Output holding stage: registers each byte and waits for the transmitter
module arfb_tx_stage
    import arfb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    arfb_byte_if.snk in_bus,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    // Ready only when the held byte is gone, so order is never disturbed
    assign in_bus.ready = !tx_valid || tx_ready;

    // Holding register; a byte stays until the transmitter accepts it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else if (in_bus.ready) begin
            tx_valid <= in_bus.valid;
            if (in_bus.valid) begin
                tx_data <= in_bus.data;
            end
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import arfb_pkg::*;
    logic sys_clk, rst_b, rsp_valid, rsp_ready, rsp_is_query, ev_valid, ev_ready, coord_formed;
    logic tx_valid, tx_ready, frame_busy, slow;
    logic [7:0] rsp_frame_id, rsp_cmd_hi, rsp_cmd_lo, rsp_status, ev_code, tx_data, drop_count, d;
    logic [4:0] rsp_data_len;
    logic [ARFB_DATA_MAX*8-1:0] rsp_data;
    logic [7:0] exp_q[$];
    logic [7:0] body[$];
    logic [7:0] codes[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0D, 8'h11, 8'h80,
        8'hFF, 8'h55};
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    arfb_frame_builder DUT (.sys_clk(sys_clk), .rst_b(rst_b), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_frame_id(rsp_frame_id), .rsp_cmd_hi(rsp_cmd_hi),
        .rsp_cmd_lo(rsp_cmd_lo), .rsp_status(rsp_status), .rsp_is_query(rsp_is_query),
        .rsp_data_len(rsp_data_len), .rsp_data(rsp_data), .ev_valid(ev_valid), .ev_ready(ev_ready),
        .ev_code(ev_code), .coord_formed(coord_formed), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .frame_busy(frame_busy), .drop_count(drop_count));
    arfb_host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("%0d compares, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Wraps the body in delimiter, length and checksum
    task automatic close_frame();
        logic [7:0] s;
        s = 8'h00;
        foreach (body[i]) s += body[i];
        exp_q = {exp_q, ARFB_DELIM, 8'h00, 8'(body.size()), body, 8'hFF - s};
        body.delete();
    endtask
    // Extra cycles after the wait catch any stray bytes
    task automatic check_frames(input string name);
        int k;
        k = 0;
        while (host.got.size() < exp_q.size() && k < 1000) begin
            step(1);
            k++;
        end
        step(4);
        chk8(8'(host.got.size()), 8'(exp_q.size()));
        chk8({7'h00, frame_busy}, 8'h00);
        foreach (exp_q[i]) chk8(host.got[i], exp_q[i]);
        host.got.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask
    task automatic send_rsp(input logic [7:0] id, input logic [7:0] st, input logic q,
        input logic [4:0] n);
        int k;
        k = 0;
        rsp_frame_id = id;
        rsp_status = st;
        rsp_is_query = q;
        rsp_data_len = n;
        rsp_valid = 1'b1;
        while (rsp_ready !== 1'b1 && k < 1000) begin
            step(1);
            k++;
        end
        rsp_valid = 1'b0;
        step(1);
        if (id != ARFB_FRAME_ID_NONE) begin
            body = {ARFB_TYPE_CMD_RSP, id, rsp_cmd_hi, rsp_cmd_lo, st};
            for (int i = 0; i < n && q; i++) body.push_back(8'hA0 + 8'(i));
            close_frame();
        end
    endtask
    task automatic send_ev(input logic [7:0] code);
        int k;
        k = 0;
        ev_code = code;
        ev_valid = 1'b1;
        while (ev_ready !== 1'b1 && k < 1000) begin
            step(1);
            k++;
        end
        ev_valid = 1'b0;
        step(1);
        body = {ARFB_TYPE_STATUS, code};
        close_frame();
    endtask
    task automatic t_replies();
        send_rsp(8'h01, 8'h00, 1'b0, 5'h00);
        check_frames("walk");
        for (int s = 0; s < 5; s++) begin
            slow = s[0];
            send_rsp(8'h10 + 8'(s), 8'(s), s != 2, 5'(4 * s));
            check_frames("status");
        end
    endtask
    task automatic t_zero();
        d = drop_count;
        send_rsp(8'h00, 8'h00, 1'b1, 5'h03);
        check_frames("zero id");
        chk8(drop_count, d + 8'h01);
    endtask
    task automatic t_multi();
        slow = 1'b1;
        send_rsp(8'h07, 8'h00, 1'b1, 5'h02);
        send_rsp(8'h07, 8'h00, 1'b1, 5'h01);
        check_frames("multi");
    endtask
    task automatic t_events();
        foreach (codes[i]) begin
            slow = i[0];
            send_ev(codes[i]);
            check_frames("event");
        end
        coord_formed = 1'b1;
        step(1);
        coord_formed = 1'b0;
        body = {ARFB_TYPE_STATUS, ARFB_EV_COORD_START};
        close_frame();
        check_frames("coord");
    endtask
    initial begin
        {rst_b, rsp_valid, rsp_is_query, ev_valid, coord_formed, slow} = 6'h00;
        {rsp_frame_id, rsp_status, ev_code, rsp_data_len} = 29'h0;
        rsp_cmd_hi = 8'h42;
        rsp_cmd_lo = 8'h44;
        for (int i = 0; i < ARFB_DATA_MAX; i++) rsp_data[8*i+:8] = 8'hA0 + 8'(i);
        step(8);
        rst_b = 1'b1;
        step(1);
        t_replies();
        t_zero();
        t_multi();
        t_events();
        results();
    end
endmodule
